// [hw/status_hierarchy.sv]
// Status reporting hierarchy: two status registers, event register, summary
`timescale 1ns/100ps
module status_hierarchy (
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// Hardware status levels from instrument pins
	input wire logic [14:0] oper_status_i,
	input wire logic [14:0] ques_status_i,
	// Same-clock status from the message and error logic
	input wire logic err_queue_not_empty_i,
	input wire logic msg_ready_i,
	input wire logic opc_done_i,
	input wire logic [7:0] std_event_i,
	// Command port
	input wire logic cmd_valid_i,
	input wire status_pkg::cmd_t cmd_i,
	// Answer port
	output logic rsp_valid_o,
	output status_pkg::rsp_t rsp_o,
	// Link-side status
	output logic srq_o,
	output logic individual_status_flag_o,
	output logic [7:0] status_summary_byte_o
);
	logic [29:0] hw_sync;
	logic wr;
	logic rd;
	logic is_oper;
	logic is_ques;
	logic is_com;
	logic [15:0] oper_cond;
	logic [15:0] oper_ptr;
	logic [15:0] oper_ntr;
	logic [15:0] oper_evt;
	logic [15:0] oper_en;
	logic oper_sum;
	logic [15:0] ques_cond;
	logic [15:0] ques_ptr;
	logic [15:0] ques_ntr;
	logic [15:0] ques_evt;
	logic [15:0] ques_en;
	logic ques_sum;
	logic oper_clr;
	logic ques_clr;
	logic ser_clr;
	logic [7:0] standard_event_register_ff;
	logic [7:0] standard_event_mask_ff;
	logic [7:0] service_request_mask_ff;
	logic [7:0] parallel_poll_mask_ff;
	logic [7:0] status_summary_byte_ff;
	logic [7:0] sumb_prev_ff;
	logic srq_ff;
	logic flag_ff;
	logic rsp_valid_ff;
	status_pkg::rsp_t rsp_ff;
	status_pkg::rsp_t nxt_rsp;
	logic [7:0] nxt_ser;
	logic [7:0] ser_set;
	logic standard_event_summary_bit;
	logic master_summary_bit;
	logic [7:0] sumb_base;
	logic [7:0] nxt_sumb;
	logic [7:0] sumb_rise;

	// Pin levels are asynchronous to the clock
	status_sync #(
		.W(30)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.async_i({ques_status_i, oper_status_i}),
		.sync_o(hw_sync)
	);

	// Command decode
	assign wr = cmd_valid_i & cmd_i.write;
	assign rd = cmd_valid_i & ~cmd_i.write;
	assign is_oper = (cmd_i.unit == status_pkg::U_OPER);
	assign is_ques = (cmd_i.unit == status_pkg::U_QUES);
	assign is_com = (cmd_i.unit == status_pkg::U_COMMON);
	assign oper_clr = rd & is_oper & (cmd_i.sel == status_pkg::P_EVT);
	assign ques_clr = rd & is_ques & (cmd_i.sel == status_pkg::P_EVT);
	assign ser_clr = rd & is_com & (cmd_i.sel == status_pkg::C_SER);

	// Activity register; its summary goes to summary byte bit 7
	status_register u_oper (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.cond_i({1'b0, hw_sync[14:0]}),
		.wr_ptr_i(wr & is_oper & (cmd_i.sel == status_pkg::P_PTR)),
		.wr_ntr_i(wr & is_oper & (cmd_i.sel == status_pkg::P_NTR)),
		.wr_en_i(wr & is_oper & (cmd_i.sel == status_pkg::P_EN)),
		.wdata_i(cmd_i.data),
		.evt_clr_i(oper_clr),
		.cond_o(oper_cond),
		.ptr_o(oper_ptr),
		.ntr_o(oper_ntr),
		.evt_o(oper_evt),
		.en_o(oper_en),
		.sum_o(oper_sum)
	);

	// Doubtful-status register; its summary goes to bit 3
	status_register u_ques (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.cond_i({1'b0, hw_sync[29:15]}),
		.wr_ptr_i(wr & is_ques & (cmd_i.sel == status_pkg::P_PTR)),
		.wr_ntr_i(wr & is_ques & (cmd_i.sel == status_pkg::P_NTR)),
		.wr_en_i(wr & is_ques & (cmd_i.sel == status_pkg::P_EN)),
		.wdata_i(cmd_i.data),
		.evt_clr_i(ques_clr),
		.cond_o(ques_cond),
		.ptr_o(ques_ptr),
		.ntr_o(ques_ntr),
		.evt_o(ques_evt),
		.en_o(ques_en),
		.sum_o(ques_sum)
	);

	// Standard event register: events set, a read clears, set wins
	always_comb begin
		ser_set = std_event_i & status_pkg::SER_USED;
		ser_set[status_pkg::SER_OPC] = ser_set[status_pkg::SER_OPC]
			| opc_done_i;
		nxt_ser = (standard_event_register_ff & ~{8{ser_clr}}) | ser_set;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i)
			standard_event_register_ff <= status_pkg::SER_RST;
		else if (ce_i)
			standard_event_register_ff <= nxt_ser;
	end

	// Masks written by command; reads never touch them
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			standard_event_mask_ff <= status_pkg::SEM_RST;
			service_request_mask_ff <= status_pkg::REQ_RST;
			parallel_poll_mask_ff <= status_pkg::PRE_RST;
		end else if (ce_i && wr && is_com) begin
			if (cmd_i.sel == status_pkg::C_SEM)
				standard_event_mask_ff <= cmd_i.data[7:0];
			if (cmd_i.sel == status_pkg::C_REQM)
				service_request_mask_ff <= cmd_i.data[7:0];
			if (cmd_i.sel == status_pkg::C_PRE)
				parallel_poll_mask_ff <= cmd_i.data[7:0];
		end
	end

	// Summary byte assembly; the master bit sums the other seven as enabled by the request mask
	always_comb begin
		standard_event_summary_bit = |(standard_event_register_ff
			& standard_event_mask_ff);
		sumb_base = 8'h00;
		sumb_base[status_pkg::SUM_ERRQ] = err_queue_not_empty_i;
		sumb_base[status_pkg::SUM_QUES] = ques_sum;
		sumb_base[status_pkg::SUM_MRDY] = msg_ready_i;
		sumb_base[status_pkg::SUM_EVT] = standard_event_summary_bit;
		sumb_base[status_pkg::SUM_OPER] = oper_sum;
		master_summary_bit = |(sumb_base & service_request_mask_ff
			& status_pkg::SRQ_MASK);
		nxt_sumb = sumb_base;
		nxt_sumb[status_pkg::SUM_MASTER] = master_summary_bit;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			status_summary_byte_ff <= 8'h00;
			sumb_prev_ff <= 8'h00;
		end else if (ce_i) begin
			status_summary_byte_ff <= nxt_sumb;
			sumb_prev_ff <= status_summary_byte_ff;
		end
	end

	// Only a fresh 0-to-1 of an enabled bit asks for service, so a
	// level that stays high does not keep requesting
	assign sumb_rise = status_summary_byte_ff & ~sumb_prev_ff;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i)
			srq_ff <= 1'b0;
		else if (ce_i)
			srq_ff <= |(sumb_rise & service_request_mask_ff
				& status_pkg::SRQ_MASK);
	end

	// Poll flag uses bit 6 too, unlike the request mask
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i)
			flag_ff <= 1'b0;
		else if (ce_i)
			flag_ff <= |(status_summary_byte_ff
				& parallel_poll_mask_ff);
	end

	// Read mux; writes to read-only parts answer with an error
	always_comb begin
		nxt_rsp = '0;
		if (is_com) begin
			unique case (cmd_i.sel)
				status_pkg::C_SUMB, status_pkg::C_SPOLL: begin
					nxt_rsp.data = {8'h00, status_summary_byte_ff};
					nxt_rsp.err = cmd_i.write;
				end
				status_pkg::C_REQM:
					nxt_rsp.data = {8'h00, service_request_mask_ff};
				status_pkg::C_PRE:
					nxt_rsp.data = {8'h00, parallel_poll_mask_ff};
				status_pkg::C_FLAG, status_pkg::C_PPOLL: begin
					nxt_rsp.data = {15'h0000, flag_ff};
					nxt_rsp.err = cmd_i.write;
				end
				status_pkg::C_SER: begin
					nxt_rsp.data = {8'h00, standard_event_register_ff};
					nxt_rsp.err = cmd_i.write;
				end
				status_pkg::C_SEM:
					nxt_rsp.data = {8'h00, standard_event_mask_ff};
			endcase
		end else if (is_oper || is_ques) begin
			case (cmd_i.sel)
				status_pkg::P_COND: begin
					nxt_rsp.data = is_oper ? oper_cond : ques_cond;
					nxt_rsp.err = cmd_i.write;
				end
				status_pkg::P_PTR:
					nxt_rsp.data = is_oper ? oper_ptr : ques_ptr;
				status_pkg::P_NTR:
					nxt_rsp.data = is_oper ? oper_ntr : ques_ntr;
				status_pkg::P_EVT: begin
					nxt_rsp.data = is_oper ? oper_evt : ques_evt;
					nxt_rsp.err = cmd_i.write;
				end
				status_pkg::P_EN:
					nxt_rsp.data = is_oper ? oper_en : ques_en;
				default:
					nxt_rsp.err = 1'b1;
			endcase
		end else begin
			nxt_rsp.err = 1'b1;
		end
		nxt_rsp.data = nxt_rsp.data & status_pkg::PART_MASK;
	end

	// Every command taken while ce_i is high gets one answer a cycle later
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			rsp_valid_ff <= 1'b0;
			rsp_ff <= '0;
		end else if (ce_i) begin
			rsp_valid_ff <= cmd_valid_i;
			if (cmd_valid_i)
				rsp_ff <= nxt_rsp;
		end
	end

	assign rsp_valid_o = rsp_valid_ff;
	assign rsp_o = rsp_ff;
	assign srq_o = srq_ff;
	assign individual_status_flag_o = flag_ff;
	assign status_summary_byte_o = status_summary_byte_ff;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	a_srq_on_rise: assert property (
		ce_i && (|(sumb_rise & service_request_mask_ff
		& status_pkg::SRQ_MASK)) |=> srq_o)
		else $error("enabled rising bit gave no service request");
	a_srq_no_cause: assert property (
		ce_i && !(|(sumb_rise & service_request_mask_ff
		& status_pkg::SRQ_MASK)) |=> !srq_o)
		else $error("service request without enabled rise");
	a_master_bit: assert property (
		ce_i && master_summary_bit |=> status_summary_byte_o[6])
		else $error("master bit not set for enabled bit");
	a_master_clear: assert property (
		ce_i && ((sumb_base & service_request_mask_ff & 8'hbf) == 8'h00)
		|=> !status_summary_byte_o[6])
		else $error("master bit set with nothing enabled");
	a_status_flag: assert property (
		ce_i && (|(status_summary_byte_ff & parallel_poll_mask_ff))
		|=> individual_status_flag_o)
		else $error("status flag missing");
	a_evt_read: assert property (
		ce_i && oper_clr |=> rsp_valid_o && (rsp_o.data == $past(oper_evt)))
		else $error("history read returned wrong value");
	a_top_bit_zero: assert property (
		rsp_valid_o |-> !rsp_o.data[15])
		else $error("top bit of a part read as one");
	a_cond_ro: assert property (
		ce_i && wr && !is_com && (cmd_i.sel == status_pkg::P_COND)
		|=> rsp_o.err)
		else $error("write to live part not refused");
	a_opc_sets: assert property (
		ce_i && opc_done_i |=> standard_event_register_ff[0])
		else $error("operation complete not recorded");
	a_mask_readback: assert property (
		ce_i && wr && is_com && (cmd_i.sel == status_pkg::C_REQM)
		|=> service_request_mask_ff == $past(cmd_i.data[7:0]))
		else $error("request mask readback mismatch");
	a_answer_next: assert property (
		ce_i && cmd_valid_i |=> rsp_valid_o ##1 (!$past(cmd_valid_i)
		|| !ce_i || rsp_valid_o))
		else $error("command not answered next cycle");
	a_errq_bit: assert property (
		ce_i && err_queue_not_empty_i |=> status_summary_byte_o[2])
		else $error("error queue bit not shown");

	c_srq: cover property (srq_o);
	c_flag: cover property (individual_status_flag_o);
	c_evt_read: cover property (oper_clr && (oper_evt != 16'h0000));
	c_srq_errq: cover property (srq_o && status_summary_byte_o[2]);
endmodule : status_hierarchy

// [hw/status_pkg.sv]
// Shared constants, field positions and carrier types for status reporting
package status_pkg;
	// Widths of register parts and the summary byte
	localparam int PART_W = 16;
	localparam int HW_W = 15;
	localparam int SUMB_W = 8;
	// Top bit of every part is forced low
	localparam logic [15:0] PART_MASK = 16'h7fff;
	// Reset values
	localparam logic [15:0] PTR_RST = 16'h7fff;
	localparam logic [15:0] NTR_RST = 16'h0000;
	localparam logic [15:0] EN_RST = 16'h0000;
	localparam logic [15:0] EVT_RST = 16'h0000;
	localparam logic [7:0] REQ_RST = 8'h00;
	localparam logic [7:0] PRE_RST = 8'h00;
	localparam logic [7:0] SEM_RST = 8'h00;
	localparam logic [7:0] SER_RST = 8'h00;
	// Summary byte bit positions
	localparam int SUM_ERRQ = 2;
	localparam int SUM_QUES = 3;
	localparam int SUM_MRDY = 4;
	localparam int SUM_EVT = 5;
	localparam int SUM_MASTER = 6;
	localparam int SUM_OPER = 7;
	// Request mask ignores bit 6; poll mask uses all bits
	localparam logic [7:0] SRQ_MASK = 8'hbf;
	// Standard event register: bit 0 operation complete, bit 1 unused
	localparam int SER_OPC = 0;
	localparam logic [7:0] SER_USED = 8'hfd;
	// Command unit select
	localparam logic [1:0] U_COMMON = 2'h0;
	localparam logic [1:0] U_OPER = 2'h1;
	localparam logic [1:0] U_QUES = 2'h2;
	// Part select inside a 16-bit status register
	localparam logic [2:0] P_COND = 3'h0;
	localparam logic [2:0] P_PTR = 3'h1;
	localparam logic [2:0] P_NTR = 3'h2;
	localparam logic [2:0] P_EVT = 3'h3;
	localparam logic [2:0] P_EN = 3'h4;
	// Select inside the common unit
	localparam logic [2:0] C_SUMB = 3'h0;
	localparam logic [2:0] C_REQM = 3'h1;
	localparam logic [2:0] C_PRE = 3'h2;
	localparam logic [2:0] C_FLAG = 3'h3;
	localparam logic [2:0] C_SER = 3'h4;
	localparam logic [2:0] C_SEM = 3'h5;
	localparam logic [2:0] C_SPOLL = 3'h6;
	localparam logic [2:0] C_PPOLL = 3'h7;
	// Command and answer carriers
	typedef struct packed {
		logic write;
		logic [1:0] unit;
		logic [2:0] sel;
		logic [15:0] data;
	} cmd_t;
	typedef struct packed {
		logic err;
		logic [15:0] data;
	} rsp_t;
endpackage : status_pkg

// [hw/status_register.sv]
// One five-part status register with edge filters and summary bit
`timescale 1ns/100ps
module status_register (
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// Live status levels
	input wire logic [15:0] cond_i,
	// Part writes and clear-on-read strobe
	input wire logic wr_ptr_i,
	input wire logic wr_ntr_i,
	input wire logic wr_en_i,
	input wire logic [15:0] wdata_i,
	input wire logic evt_clr_i,
	// Part contents and summary
	output logic [15:0] cond_o,
	output logic [15:0] ptr_o,
	output logic [15:0] ntr_o,
	output logic [15:0] evt_o,
	output logic [15:0] en_o,
	output logic sum_o
);
	logic [15:0] cond_ff;
	logic [15:0] ptr_ff;
	logic [15:0] ntr_ff;
	logic [15:0] evt_ff;
	logic [15:0] en_ff;
	logic [15:0] set_w;
	logic [15:0] nxt_evt;

	// Live part follows its source only; no write path exists
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i)
			cond_ff <= '0;
		else if (ce_i)
			cond_ff <= cond_i & status_pkg::PART_MASK;
	end

	// Filters and mask: written on command, reads leave them alone
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			ptr_ff <= status_pkg::PTR_RST;
			ntr_ff <= status_pkg::NTR_RST;
			en_ff <= status_pkg::EN_RST;
		end else if (ce_i) begin
			if (wr_ptr_i)
				ptr_ff <= wdata_i & status_pkg::PART_MASK;
			if (wr_ntr_i)
				ntr_ff <= wdata_i & status_pkg::PART_MASK;
			if (wr_en_i)
				en_ff <= wdata_i & status_pkg::PART_MASK;
		end
	end

	// Filtered edges; a new edge beats a clear in the same cycle
	always_comb begin
		set_w = (cond_i & ~cond_ff & ptr_ff)
			| (~cond_i & cond_ff & ntr_ff);
		set_w = set_w & status_pkg::PART_MASK;
		nxt_evt = (evt_ff & ~{16{evt_clr_i}}) | set_w;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i)
			evt_ff <= status_pkg::EVT_RST;
		else if (ce_i)
			evt_ff <= nxt_evt;
	end

	assign cond_o = cond_ff;
	assign ptr_o = ptr_ff;
	assign ntr_o = ntr_ff;
	assign evt_o = evt_ff;
	assign en_o = en_ff;
	assign sum_o = |(evt_ff & en_ff);

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	a_edge_latched: assert property (
		ce_i && (set_w != 16'h0000) |=> ((evt_ff & $past(set_w)) == $past(set_w)))
		else $error("filtered edge not latched");
	a_history_held: assert property (
		ce_i && !evt_clr_i && (set_w == 16'h0000) |=> $stable(evt_ff))
		else $error("history changed without edge or read");
endmodule : status_register

// [hw/status_sync.sv]
// Two-flop synchroniser for a bus of independent status levels
`timescale 1ns/100ps
module status_sync #(
	parameter int W = 15
) (
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// Levels from outside the clock domain
	input wire logic [W-1:0] async_i,
	// Synchronised levels
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// First stage feeds only the second; bits are independent levels
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else if (ce_i) begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;
endmodule : status_sync

// [sim/remote_ctrl_model.sv]
// Remote controller model issuing commands and counting service requests
`timescale 1ns/100ps
module remote_ctrl_model (
	// Clock
	input wire logic ref_clk_i,
	// Command side
	output logic cmd_valid_o,
	output status_pkg::cmd_t cmd_o,
	// Service request side
	input wire logic srq_i,
	output int srq_cnt_o
);
	// Idle command bus until the first request
	initial begin
		cmd_valid_o = 1'b0;
		cmd_o = '0;
		srq_cnt_o = 0;
	end

	// One command per call; held across exactly one taking edge
	task automatic send(input logic w, input logic [1:0] u,
		input logic [2:0] s, input logic [15:0] d);
		@(negedge ref_clk_i);
		cmd_valid_o = 1'b1;
		cmd_o = '{write: w, unit: u, sel: s, data: d};
		@(negedge ref_clk_i);
		cmd_valid_o = 1'b0;
		cmd_o.data = ~d; // Stale data never looks valid
	endtask : send

	// Request is a one-cycle pulse, so sample mid-cycle
	always @(negedge ref_clk_i) begin
		if (srq_i === 1'b1) begin
			srq_cnt_o++;
		end
	end
endmodule : remote_ctrl_model

// [sim/status_hierarchy_tb_top.sv]
// Self-checking bench for the status reporting hierarchy
`timescale 1ns/100ps
module status_hierarchy_tb_top;
	logic ref_clk_i;
	logic rst_b_i;
	logic ce_i;
	logic [14:0] oper;
	logic [14:0] ques;
	logic errq;
	logic mrdy;
	logic opc;
	logic [7:0] std_ev;
	logic cmd_valid;
	status_pkg::cmd_t cmd;
	logic rsp_valid;
	status_pkg::rsp_t rsp;
	logic srq;
	logic flag;
	logic [7:0] sumb;
	int srq_cnt;
	int n_mismatch;
	int cmp_count;
	int cycles;
	int seed;
	logic [15:0] r;
	logic [15:0] ev_r;
	logic [17:0] exp_q[$];
	logic [15:0] sh[3][8];

	// Design and far-side controller
	status_hierarchy u_status_hierarchy (.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i), .ce_i(ce_i), .oper_status_i(oper),
		.ques_status_i(ques), .err_queue_not_empty_i(errq),
		.msg_ready_i(mrdy), .opc_done_i(opc), .std_event_i(std_ev),
		.cmd_valid_i(cmd_valid), .cmd_i(cmd), .rsp_valid_o(rsp_valid),
		.rsp_o(rsp), .srq_o(srq), .individual_status_flag_o(flag),
		.status_summary_byte_o(sumb));
	remote_ctrl_model u_remote_ctrl_model (.ref_clk_i(ref_clk_i),
		.cmd_valid_o(cmd_valid), .cmd_o(cmd), .srq_i(srq),
		.srq_cnt_o(srq_cnt));

	// 100 ns clock
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic give_verdict;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict

	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : wt

	// Note the answer first, then hand the command to the controller
	task automatic xf(input logic w, input logic [1:0] u, input logic [2:0] s,
		input logic [15:0] d, input logic [17:0] e);
		exp_q.push_back(e);
		u_remote_ctrl_model.send(w, u, s, d);
	endtask : xf

	// Writes answer with the old value; shadow keeps the new one
	task automatic wr(input logic [1:0] u, input logic [2:0] s,
		input logic [15:0] d);
		logic [15:0] m;
		m = (u == 2'd0) ? 16'h00ff : 16'h7fff;
		xf(1'b1, u, s, d & ((u == 2'd0) ? 16'h00ff : 16'hffff),
			{2'b10, sh[u][s]});
		sh[u][s] = d & m;
	endtask : wr

	task automatic rd(input logic [1:0] u, input logic [2:0] s,
		input logic [15:0] e);
		xf(1'b0, u, s, 16'h0000, {2'b10, e});
	endtask : rd

	// Refused request: error flag, data checked only when defined
	task automatic bad(input logic w, input logic [1:0] u, input logic [2:0] s,
		input logic c);
		xf(w, u, s, 16'h1234, {c, 1'b1, 16'h0000});
	endtask : bad

	// Answer monitor takes the oldest note for each answer
	always @(negedge ref_clk_i) begin : mon
		logic [17:0] e;
		if (rsp_valid === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 18'h3_ffff;
			chk("rsp_err", {31'h0, rsp.err}, {31'h0, e[16]});
			if (e[17]) begin
				chk("rsp_data", {16'h0, rsp.data}, {16'h0, e[15:0]});
			end
		end
	end

	// Hang guard, well above the expected run length
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial begin
		seed = 89;
		n_mismatch = 0;
		cmp_count = 0;
		cycles = 0;
		rst_b_i = 1'b0;
		ce_i = 1'b1;
		oper = '0;
		ques = '0;
		errq = 1'b0;
		mrdy = 1'b0;
		opc = 1'b0;
		std_ev = '0;
		foreach (sh[u, s]) sh[u][s] = 16'h0000;
		sh[1][1] = 16'h7fff;
		sh[2][1] = 16'h7fff;
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_b_i = 1'b1;
		chk("sumb_rst", {24'h0, sumb}, 32'h0000_0000);
		// Reset contents of filters, masks and history
		for (int u = 0; u < 3; u++) begin
			for (int s = 1; s < 6; s++) begin
				if (u != 0 && s == 5 || u == 0 && s == 3) continue;
				rd(2'(u), 3'(s), sh[u][s]);
			end
		end
		// Random writes, read back twice, top bit forced low
		for (int u = 0; u < 3; u++) begin
			for (int s = 1; s < 6; s++) begin
				if (s == 3 || (u == 0 ? s == 4 : s == 5)) continue;
				r = 16'($random(seed));
				wr(2'(u), 3'(s), r);
				rd(2'(u), 3'(s), sh[u][s]);
				rd(2'(u), 3'(s), sh[u][s]);
			end
		end
		wr(2'd1, status_pkg::P_NTR, 16'hffff);
		rd(2'd1, status_pkg::P_NTR, 16'h7fff);
		// Refused requests on read-only and unknown places
		for (int s = 0; s < 8; s++) begin
			if (s == 1 || s == 2 || s == 5) continue;
			bad(1'b1, 2'd0, 3'(s), 1'b0);
		end
		bad(1'b1, 2'd1, status_pkg::P_COND, 1'b0);
		bad(1'b1, 2'd2, status_pkg::P_EVT, 1'b0);
		bad(1'b0, 2'd3, 3'd0, 1'b1);
		bad(1'b0, 2'd1, 3'd6, 1'b1);
		// Edge filters: rising on bit 0, falling on bit 1
		wr(2'd1, status_pkg::P_PTR, 16'h0001);
		wr(2'd1, status_pkg::P_NTR, 16'h0002);
		oper = 15'h0003;
		wt(6);
		rd(2'd1, status_pkg::P_COND, 16'h0003);
		rd(2'd1, status_pkg::P_EVT, 16'h0001);
		rd(2'd1, status_pkg::P_EVT, 16'h0000);
		rd(2'd1, status_pkg::P_COND, 16'h0003);
		oper = 15'h0000;
		wt(6);
		rd(2'd1, status_pkg::P_EVT, 16'h0002);
		// Summaries climbing to the byte and the request line
		wr(2'd2, status_pkg::P_PTR, 16'h7fff);
		wr(2'd2, status_pkg::P_EN, 16'h0004);
		wr(2'd1, status_pkg::P_PTR, 16'h0100);
		wr(2'd1, status_pkg::P_EN, 16'h0100);
		wr(2'd0, status_pkg::C_REQM, 16'h00c8);
		wt(4);
		r = 16'(srq_cnt);
		ques = 15'h0004;
		wt(8);
		chk("sumb_q", {24'h0, sumb}, 32'h0000_0048);
		chk("srq_q", srq_cnt, r + 1);
		rd(2'd2, status_pkg::P_COND, 16'h0004);
		oper = 15'h0100;
		wt(8);
		chk("sumb_o", {24'h0, sumb}, 32'h0000_00c8);
		rd(2'd0, status_pkg::C_SUMB, 16'h00c8);
		rd(2'd0, status_pkg::C_SPOLL, 16'h00c8);
		errq = 1'b1;
		wt(4);
		chk("sumb_e", {24'h0, sumb}, 32'h0000_00cc);
		chk("srq_o", srq_cnt, r + 2);
		// Every new error entry requests service once enabled
		wr(2'd0, status_pkg::C_REQM, 16'h0004);
		for (int i = 0; i < 2; i++) begin
			errq = 1'b0;
			wt(4);
			errq = 1'b1;
			wt(4);
		end
		chk("srq_e", srq_cnt, r + 4);
		wr(2'd0, status_pkg::C_REQM, 16'h0040);
		wt(4);
		chk("master_off", {31'h0, sumb[6]}, 32'h0000_0000);
		mrdy = 1'b1;
		wt(4);
		chk("sumb_m", {24'h0, sumb}, 32'h0000_009c);
		// Operation complete and masked event summary
		wr(2'd0, status_pkg::C_SEM, 16'h0001);
		opc = 1'b1;
		wt(1);
		opc = 1'b0;
		wt(4);
		chk("sumb_ev", {24'h0, sumb}, 32'h0000_00bc);
		rd(2'd0, status_pkg::C_SER, 16'h0001);
		wt(4);
		chk("evsum_clr", {31'h0, sumb[5]}, 32'h0000_0000);
		ev_r = 16'($random(seed));
		std_ev = ev_r[7:0];
		wt(1);
		std_ev = 8'h00;
		wt(3);
		rd(2'd0, status_pkg::C_SER, {8'h00, ev_r[7:0] & 8'hfd});
		// Poll flag, bit 6 taking part
		wr(2'd0, status_pkg::C_PRE, 16'h0040);
		wt(4);
		chk("flag_0", {31'h0, flag}, 32'h0000_0000);
		wr(2'd0, status_pkg::C_REQM, 16'h0010);
		wt(4);
		chk("flag_1", {31'h0, flag}, 32'h0000_0001);
		rd(2'd0, status_pkg::C_FLAG, 16'h0001);
		rd(2'd0, status_pkg::C_PPOLL, 16'h0001);
		wr(2'd0, status_pkg::C_PRE, 16'h0001);
		wt(4);
		chk("flag_b0", {31'h0, flag}, 32'h0000_0000);
		// Enable low freezes the byte; it catches up once released
		ce_i = 1'b0;
		mrdy = 1'b0;
		wt(4);
		chk("ce_hold", {24'h0, sumb}, 32'h0000_00dc);
		ce_i = 1'b1;
		wt(4);
		chk("ce_run", {24'h0, sumb}, 32'h0000_008c);
		chk("srq_end", srq_cnt, r + 4);
		wt(5);
		chk("q_left", exp_q.size(), 32'h0000_0000);
		give_verdict();
	end
endmodule : status_hierarchy_tb_top
